// ===== svwd_defs.vh
// Constants for the supervisor watchdog and status logic.
`ifndef SVWD_DEFS_VH
`define SVWD_DEFS_VH

// Reference clock and nominal internal oscillator, in hertz.
`define SVWD_REF_CLK_HZ      125000000
`define SVWD_INT_OSC_HZ      10240
// Reference cycles per internal oscillator period, 125 MHz over 10.24 kHz
// rounded down, sized to the divider width.
`define SVWD_INT_DIV_CYCLES  16'h2FAF

// Internal-oscillator times in milliseconds.
`define SVWD_T_SHORT_MS      100
`define SVWD_T_LONG_MS       1600
`define SVWD_T_RST_MS        50
`define SVWD_T_RST_LONG_MS   200
// The same times as counts of 10.24 kHz oscillator periods.
`define SVWD_INT_SHORT_TICKS 16'h0400
`define SVWD_INT_LONG_TICKS  16'h4000
`define SVWD_INT_RST_TICKS   16'h0200
`define SVWD_INT_RSTL_TICKS  16'h0800

// External timebase counts, in timebase clocks.
`define SVWD_EXT_SHORT_TICKS 16'h0400
`define SVWD_EXT_LONG_TICKS  16'h1000
`define SVWD_EXT_RST_TICKS   16'h0200
`define SVWD_EXT_RSTL_TICKS  16'h0800

// Width of the tick counters.
`define SVWD_CNT_W           16
// Width of the internal divider.
`define SVWD_DIV_W           16

// Reset values of the outputs.
`define SVWD_RST_OUT_N       1'h0
`define SVWD_FLAG_N_RST      1'h1

`endif

// ===== svwd_host_model.sv
// Host processor and timebase source facing the supervisor.
`timescale 1ns/1ps
module svwd_host_model #(
   parameter integer KICK_GAP = 400
) (
   // Clock
   input  wire ref_clk_in,
   // Requests from the bench
   input  wire kick_run_in,
   input  wire kick_now_in,
   input  wire float_in,
   input  wire ext_clk_run_in,
   input  wire pin_level_in,
   // Lines toward the supervisor
   output reg  kick_out,
   output wire kick_float_out,
   output wire timebase_pin_out
);
   integer   gap = 0;
   reg       pin_clk = 1'h0;
   reg [1:0] div = 2'h0;
   initial kick_out = 1'h0;
   assign kick_float_out = float_in;
   // The clock only runs while requested, one rising edge per four cycles.
   assign timebase_pin_out = ext_clk_run_in ? pin_clk : pin_level_in;
   always @(negedge ref_clk_in) begin
      div <= div + 2'h1;
      pin_clk <= div[1];
      // A released kick line reads as noise that changes every cycle.
      if (float_in || kick_now_in) begin
         kick_out <= ~kick_out;
      end else if (kick_run_in) begin
         gap = gap + 1;
         if (gap >= KICK_GAP) begin
            gap = 0;
            kick_out <= ~kick_out;
         end
      end
   end
endmodule

// ===== svwd_supervisor.v
// Supervisor watchdog, reset pulse timing and status output logic.
`timescale 1ns/1ps
`include "svwd_defs.vh"

module svwd_supervisor #(
   parameter [`SVWD_DIV_W-1:0] INT_DIV_CYCLES = `SVWD_INT_DIV_CYCLES
) (
   // Clock and reset
   input  wire ref_clk_in,
   input  wire rst_n_in,
   // Decoded analog conditions
   input  wire pf_sense_low_in,
   input  wire main_below_backup_in,
   input  wire supply_below_thresh_in,
   input  wire on_backup_supply_in,
   // Chip-select gating
   input  wire select_n_in,
   // Timebase selection
   input  wire timebase_source_sel_in,
   input  wire timebase_pin_in,
   input  wire long_reset_variant_in,
   // Three-level kick input, decoded
   input  wire kick_input_in,
   input  wire kick_float_in,
   // Status outputs
   output reg  power_fail_flag_n_out,
   output reg  select_n_out,
   output reg  on_backup_supply_out,
   output reg  supply_low_n_out,
   // Reset outputs
   output reg  reset_n_out,
   output reg  reset_out,
   // Watchdog flag
   output reg  kick_timeout_flag_n_out
);

   localparam [1:0] ST_RESET = 2'h1;
   localparam [1:0] ST_RUN   = 2'h2;

   localparam [`SVWD_CNT_W-1:0] INT_SHORT = `SVWD_INT_SHORT_TICKS;
   localparam [`SVWD_CNT_W-1:0] INT_LONG  = `SVWD_INT_LONG_TICKS;
   localparam [`SVWD_CNT_W-1:0] INT_RST   = `SVWD_INT_RST_TICKS;
   localparam [`SVWD_CNT_W-1:0] INT_RSTL  = `SVWD_INT_RSTL_TICKS;
   localparam [`SVWD_CNT_W-1:0] EXT_SHORT = `SVWD_EXT_SHORT_TICKS;
   localparam [`SVWD_CNT_W-1:0] EXT_LONG  = `SVWD_EXT_LONG_TICKS;
   localparam [`SVWD_CNT_W-1:0] EXT_RST   = `SVWD_EXT_RST_TICKS;
   localparam [`SVWD_CNT_W-1:0] EXT_RSTL  = `SVWD_EXT_RSTL_TICKS;

   wire                   tick;
   wire                   pin_level;

   // Condition synchronizers: first stage feeds only the second.
   reg                    pfl_meta_reg;
   reg                    pfl_sync_reg;
   reg                    mbb_meta_reg;
   reg                    mbb_sync_reg;
   reg                    sbt_meta_reg;
   reg                    sbt_sync_reg;
   reg                    bak_meta_reg;
   reg                    bak_sync_reg;
   reg                    kin_meta_reg;
   reg                    kin_sync_reg;
   reg                    kfl_meta_reg;
   reg                    kfl_sync_reg;
   reg                    sel_meta_reg;
   reg                    sel_sync_reg;
   reg                    lrv_meta_reg;
   reg                    lrv_sync_reg;
   reg                    kin_prev_reg;

   reg [1:0]              state_reg;
   reg [1:0]              state_next;
   reg [`SVWD_CNT_W-1:0]  rst_cnt_reg;
   reg [`SVWD_CNT_W-1:0]  rst_cnt_next;
   reg [`SVWD_CNT_W-1:0]  wd_cnt_reg;
   reg [`SVWD_CNT_W-1:0]  wd_cnt_next;
   reg                    long_mode_reg;
   reg                    long_mode_next;
   reg                    flag_n_next;
   reg                    reset_n_next;

   wire                   kick_edge;
   wire                   use_internal;
   wire [`SVWD_CNT_W-1:0] wd_limit;
   wire [`SVWD_CNT_W-1:0] rst_limit;

   // Chooses between the internal and external tick count for a period.
   function [`SVWD_CNT_W-1:0] pick;
      input                   internal;
      input [`SVWD_CNT_W-1:0] int_ticks;
      input [`SVWD_CNT_W-1:0] ext_ticks;
      begin
         pick = internal ? int_ticks : ext_ticks;
      end
   endfunction

   svwd_timebase #(
      .INT_DIV_CYCLES (INT_DIV_CYCLES)
   ) u_timebase (
      .ref_clk_in             (ref_clk_in),
      .rst_n_in               (rst_n_in),
      .timebase_source_sel_in (timebase_source_sel_in),
      .timebase_pin_in        (timebase_pin_in),
      .tick_out               (tick),
      .pin_level_out          (pin_level)
   );

   assign use_internal = sel_sync_reg;
   assign kick_edge    = (kin_sync_reg ^ kin_prev_reg) & ~kfl_sync_reg;

   // After a reset the long period holds; with the internal timebase the pin picks the normal one.
   assign wd_limit =
      long_mode_reg ? pick(use_internal, INT_LONG, EXT_LONG) :
      (use_internal ? (pin_level ? INT_LONG : INT_SHORT)
                    : EXT_SHORT);
   assign rst_limit = lrv_sync_reg ?
      pick(use_internal, INT_RSTL, EXT_RSTL) :
      pick(use_internal, INT_RST, EXT_RST);

   // Watchdog and reset pulse sequencing.
   always @* begin
      state_next     = state_reg;
      rst_cnt_next   = rst_cnt_reg;
      wd_cnt_next    = wd_cnt_reg;
      long_mode_next = long_mode_reg;
      flag_n_next    = kick_timeout_flag_n_out;
      reset_n_next   = reset_n_out;
      if (kick_edge) begin
         flag_n_next = 1'h1;
      end
      case (state_reg)
         ST_RESET: begin
            reset_n_next   = 1'h0;
            long_mode_next = 1'h1;
            wd_cnt_next    = {`SVWD_CNT_W{1'b0}};
            if (sbt_sync_reg) begin
               rst_cnt_next = {`SVWD_CNT_W{1'b0}};
            end else if (tick) begin
               if (rst_cnt_reg >= rst_limit - 16'h0001) begin
                  // Pulse over: the watchdog starts afresh on the long period.
                  rst_cnt_next = {`SVWD_CNT_W{1'b0}};
                  reset_n_next = 1'h1;
                  state_next   = ST_RUN;
               end else begin
                  rst_cnt_next = rst_cnt_reg + 16'h0001;
               end
            end
         end
         ST_RUN: begin
            reset_n_next = 1'h1;
            if (sbt_sync_reg) begin
               reset_n_next = 1'h0;
               state_next   = ST_RESET;
               wd_cnt_next  = {`SVWD_CNT_W{1'b0}};
            end else if (kfl_sync_reg) begin
               wd_cnt_next = {`SVWD_CNT_W{1'b0}};
               flag_n_next = 1'h1;
            end else if (kick_edge) begin
               wd_cnt_next    = {`SVWD_CNT_W{1'b0}};
               long_mode_next = 1'h0;
            end else if (tick) begin
               if (wd_cnt_reg >= wd_limit - 16'h0001) begin
                  wd_cnt_next  = {`SVWD_CNT_W{1'b0}};
                  flag_n_next  = 1'h0;
                  reset_n_next = 1'h0;
                  rst_cnt_next = {`SVWD_CNT_W{1'b0}};
                  state_next   = ST_RESET;
               end else begin
                  wd_cnt_next = wd_cnt_reg + 16'h0001;
               end
            end
         end
         default: begin
            state_next   = ST_RESET;
            reset_n_next = 1'h0;
         end
      endcase
      // A floating kick line keeps the flag high even during a reset pulse.
      if (kfl_sync_reg) begin
         flag_n_next = 1'h1;
      end
      if (sbt_sync_reg) begin
         flag_n_next = 1'h1;
      end
   end

   always @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         pfl_meta_reg <= 1'h0;
         pfl_sync_reg <= 1'h0;
         mbb_meta_reg <= 1'h0;
         mbb_sync_reg <= 1'h0;
         sbt_meta_reg <= 1'h1;
         sbt_sync_reg <= 1'h1;
         bak_meta_reg <= 1'h0;
         bak_sync_reg <= 1'h0;
         kin_meta_reg <= 1'h0;
         kin_sync_reg <= 1'h0;
         kfl_meta_reg <= 1'h1;
         kfl_sync_reg <= 1'h1;
         sel_meta_reg <= 1'h1;
         sel_sync_reg <= 1'h1;
         lrv_meta_reg <= 1'h0;
         lrv_sync_reg <= 1'h0;
         kin_prev_reg <= 1'h0;
      end else begin
         pfl_meta_reg <= pf_sense_low_in;
         pfl_sync_reg <= pfl_meta_reg;
         mbb_meta_reg <= main_below_backup_in;
         mbb_sync_reg <= mbb_meta_reg;
         sbt_meta_reg <= supply_below_thresh_in;
         sbt_sync_reg <= sbt_meta_reg;
         bak_meta_reg <= on_backup_supply_in;
         bak_sync_reg <= bak_meta_reg;
         kin_meta_reg <= kick_input_in;
         kin_sync_reg <= kin_meta_reg;
         kfl_meta_reg <= kick_float_in;
         kfl_sync_reg <= kfl_meta_reg;
         sel_meta_reg <= timebase_source_sel_in;
         sel_sync_reg <= sel_meta_reg;
         lrv_meta_reg <= long_reset_variant_in;
         lrv_sync_reg <= lrv_meta_reg;
         kin_prev_reg <= kin_sync_reg;
      end
   end

   always @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         state_reg               <= ST_RESET;
         rst_cnt_reg             <= {`SVWD_CNT_W{1'b0}};
         wd_cnt_reg              <= {`SVWD_CNT_W{1'b0}};
         long_mode_reg           <= 1'h1;
         reset_n_out             <= `SVWD_RST_OUT_N;
         reset_out               <= ~`SVWD_RST_OUT_N;
         kick_timeout_flag_n_out <= `SVWD_FLAG_N_RST;
      end else begin
         state_reg               <= state_next;
         rst_cnt_reg             <= rst_cnt_next;
         wd_cnt_reg              <= wd_cnt_next;
         long_mode_reg           <= long_mode_next;
         reset_n_out             <= reset_n_next;
         reset_out               <= ~reset_n_next;
         kick_timeout_flag_n_out <= flag_n_next;
      end
   end

   // Status outputs follow the synchronized conditions, and select_n_in directly, one cycle later.
   always @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         power_fail_flag_n_out <= 1'h0;
         select_n_out          <= 1'h1;
         on_backup_supply_out  <= 1'h0;
         supply_low_n_out      <= 1'h0;
      end else begin
         power_fail_flag_n_out <= ~(pfl_sync_reg | mbb_sync_reg);
         select_n_out          <= select_n_in | sbt_sync_reg;
         on_backup_supply_out  <= bak_sync_reg;
         supply_low_n_out      <= ~sbt_sync_reg;
      end
   end

endmodule

// ===== svwd_supervisor_props.sv
// Concurrent checks on the supervisor ports, bound to the design.
`timescale 1ns/1ps
module svwd_props (
   // Clock and reset
   input wire ref_clk_in,
   input wire rst_n_in,
   // Condition and kick inputs
   input wire pf_sense_low_in,
   input wire main_below_backup_in,
   input wire supply_below_thresh_in,
   input wire on_backup_supply_in,
   input wire select_n_in,
   input wire kick_input_in,
   input wire kick_float_in,
   // Outputs
   input wire power_fail_flag_n_out,
   input wire select_n_out,
   input wire on_backup_supply_out,
   input wire supply_low_n_out,
   input wire reset_n_out,
   input wire reset_out,
   input wire kick_timeout_flag_n_out
);
   wire pf_any;
   assign pf_any = pf_sense_low_in | main_below_backup_in;
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!rst_n_in);
   pf_flag_a: assert property ($stable(pf_any)[*3] |=>
      power_fail_flag_n_out == !$past(pf_any)) else $error("pf flag wrong");
   sel_gate_a: assert property (supply_below_thresh_in[*3] |=>
      select_n_out) else $error("select not gated");
   sel_follow_a: assert property (!supply_below_thresh_in[*3] |=>
      select_n_out == $past(select_n_in)) else $error("select not passed");
   backup_ind_a: assert property ($stable(on_backup_supply_in)[*3] |=>
      on_backup_supply_out == $past(on_backup_supply_in))
      else $error("backup indicator wrong");
   supply_low_a: assert property ($stable(supply_below_thresh_in)[*3] |=>
      supply_low_n_out == !$past(supply_below_thresh_in))
      else $error("supply low output wrong");
   reset_pair_a: assert property (reset_out == !reset_n_out)
      else $error("reset outputs not complementary");
   wd_reset_a: assert property ($fell(kick_timeout_flag_n_out) |->
      !reset_n_out && reset_out) else $error("timeout without reset");
   flag_low_a: assert property (!supply_low_n_out[*2] |->
      kick_timeout_flag_n_out) else $error("flag low with supply low");
   float_off_a: assert property (kick_float_in[*4] |=>
      kick_timeout_flag_n_out) else $error("flag low while floating");
   kick_clear_a: assert property ($changed(kick_input_in) &&
      !kick_float_in |-> ##[1:5] kick_timeout_flag_n_out)
      else $error("kick did not clear flag");
   cover property ($fell(kick_timeout_flag_n_out));
   cover property ($rose(reset_n_out));
   cover property (kick_float_in[*4]);
endmodule
bind svwd_supervisor svwd_props svwd_props_i (
   .ref_clk_in              (ref_clk_in),
   .rst_n_in                (rst_n_in),
   .pf_sense_low_in         (pf_sense_low_in),
   .main_below_backup_in    (main_below_backup_in),
   .supply_below_thresh_in  (supply_below_thresh_in),
   .on_backup_supply_in     (on_backup_supply_in),
   .select_n_in             (select_n_in),
   .kick_input_in           (kick_input_in),
   .kick_float_in           (kick_float_in),
   .power_fail_flag_n_out   (power_fail_flag_n_out),
   .select_n_out            (select_n_out),
   .on_backup_supply_out    (on_backup_supply_out),
   .supply_low_n_out        (supply_low_n_out),
   .reset_n_out             (reset_n_out),
   .reset_out               (reset_out),
   .kick_timeout_flag_n_out (kick_timeout_flag_n_out)
);

// ===== svwd_timebase.v
// Timebase tick generator: internal divider or external timebase pin.
`timescale 1ns/1ps
`include "svwd_defs.vh"

module svwd_timebase #(
   parameter [`SVWD_DIV_W-1:0] INT_DIV_CYCLES = `SVWD_INT_DIV_CYCLES
) (
   // Clock and reset
   input  wire ref_clk_in,
   input  wire rst_n_in,
   // Source selection and external pin
   input  wire timebase_source_sel_in,
   input  wire timebase_pin_in,
   // Tick and synchronized pin level
   output reg  tick_out,
   output wire pin_level_out
);

   reg                   pin_meta_reg;
   reg                   pin_sync_reg;
   reg                   pin_prev_reg;
   reg                   sel_meta_reg;
   reg                   sel_sync_reg;
   reg [`SVWD_DIV_W-1:0] div_reg;
   reg [`SVWD_DIV_W-1:0] div_next;
   reg                   tick_next;

   assign pin_level_out = pin_sync_reg;

   always @* begin
      div_next  = div_reg;
      tick_next = 1'h0;
      if (sel_sync_reg) begin
         if (div_reg >= INT_DIV_CYCLES - 16'h0001) begin
            div_next  = {`SVWD_DIV_W{1'b0}};
            tick_next = 1'h1;
         end else begin
            div_next = div_reg + 16'h0001;
         end
      end else begin
         // Each rising edge of the external clock or RC swing is a tick.
         div_next  = {`SVWD_DIV_W{1'b0}};
         tick_next = pin_sync_reg & ~pin_prev_reg;
      end
   end

   always @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         pin_meta_reg <= 1'h0;
         pin_sync_reg <= 1'h0;
         pin_prev_reg <= 1'h0;
         sel_meta_reg <= 1'h1;
         sel_sync_reg <= 1'h1;
         div_reg      <= {`SVWD_DIV_W{1'b0}};
         tick_out     <= 1'h0;
      end else begin
         pin_meta_reg <= timebase_pin_in;
         pin_sync_reg <= pin_meta_reg;
         pin_prev_reg <= pin_sync_reg;
         sel_meta_reg <= timebase_source_sel_in;
         sel_sync_reg <= sel_meta_reg;
         div_reg      <= div_next;
         tick_out     <= tick_next;
      end
   end

endmodule

// ===== tb.sv
// Self-checking bench for the supervisor watchdog and status logic.
`timescale 1ns/1ps
module tb;
   localparam [15:0] DIV = 16'h0003;
   localparam [29:0] VEC = {5'h10, 5'h09, 5'h06, 5'h02, 5'h1F, 5'h00};
   reg     ref_clk_in = 1'h0, rst_n_in = 1'h0;
   reg     pf = 1'h0, mbb = 1'h0, sb = 1'h0, ob = 1'h0, sel_n = 1'h1;
   reg     src_sel = 1'h0, pin_lvl = 1'h0, long_var = 1'h0;
   reg     kick_run = 1'h0, kick_now = 1'h0, flt = 1'h0, ext_run = 1'h1;
   wire    kick, kick_flt, pin, pf_n, sel_o, onb, sl_n, rst_n_o, rst_o;
   wire    flag_n;
   integer mismatches = 0;
   integer samples_checked = 0;
   integer n, i, f0, falls = 0;
   svwd_host_model svwd_host_model_i (.ref_clk_in(ref_clk_in),
      .kick_run_in(kick_run), .kick_now_in(kick_now), .float_in(flt),
      .ext_clk_run_in(ext_run), .pin_level_in(pin_lvl), .kick_out(kick),
      .kick_float_out(kick_flt), .timebase_pin_out(pin));
   svwd_supervisor #(.INT_DIV_CYCLES(DIV)) svwd_supervisor_i (
      .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .pf_sense_low_in(pf),
      .main_below_backup_in(mbb), .supply_below_thresh_in(sb),
      .on_backup_supply_in(ob), .select_n_in(sel_n),
      .timebase_source_sel_in(src_sel), .timebase_pin_in(pin),
      .long_reset_variant_in(long_var), .kick_input_in(kick),
      .kick_float_in(kick_flt), .power_fail_flag_n_out(pf_n),
      .select_n_out(sel_o), .on_backup_supply_out(onb),
      .supply_low_n_out(sl_n), .reset_n_out(rst_n_o), .reset_out(rst_o),
      .kick_timeout_flag_n_out(flag_n));
   initial forever #4 ref_clk_in = ~ref_clk_in;
   always @(negedge flag_n) falls = falls + 1;
   task check_bit(input logic got, input logic exp);
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
         mismatches = mismatches + 1;
         $display("CHECK FAILED at %0t: got %b want %b", $time, got, exp);
      end
   endtask
   task check_range(input integer got, input integer lo, input integer hi);
      samples_checked = samples_checked + 1;
      if (got < lo || got > hi) begin
         mismatches = mismatches + 1;
         $display("CHECK FAILED at %0t: count %0d not in %0d..%0d", $time,
            got, lo, hi);
      end
   endtask
   // Counts cycles until reset (sel 0) or the flag (sel 1) reaches lvl.
   task wait_for(input integer sel, input logic lvl, input integer lim,
                 output integer cnt);
      cnt = 0;
      while (((sel == 0) ? rst_n_o : flag_n) !== lvl && cnt < lim) begin
         @(negedge ref_clk_in);
         cnt = cnt + 1;
      end
   endtask
   task kick_once;
      kick_now <= 1'h1;
      @(negedge ref_clk_in);
      kick_now <= 1'h0;
      @(negedge ref_clk_in);
   endtask
   task finish_test;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      #800000;
      mismatches = mismatches + 1;
      finish_test;
   end
   initial begin
      repeat (20) @(negedge ref_clk_in);
      rst_n_in <= 1'h1;
      for (i = 0; i < 6; i = i + 1) begin
         {pf, mbb, sb, ob, sel_n} <= VEC[i*5 +: 5];
         repeat (5) @(negedge ref_clk_in);
         check_bit(pf_n, !(pf | mbb));
         check_bit(sel_o, sel_n | sb);
         check_bit(onb, ob);
         check_bit(sl_n, !sb);
         check_bit(rst_o, !rst_n_o);
      end
      $display("status test done");
      rst_n_in <= 1'h0;
      repeat (4) @(negedge ref_clk_in);
      rst_n_in <= 1'h1;
      wait_for(0, 1'h1, 3000, n);
      check_range(n, 2040, 2064);
      wait_for(1, 1'h0, 17000, n);
      check_range(n, 16370, 16400);
      check_bit(rst_n_o, 1'h0);
      check_bit(rst_o, 1'h1);
      kick_once;
      repeat (5) @(negedge ref_clk_in);
      check_bit(flag_n, 1'h1);
      wait_for(0, 1'h1, 3000, n);
      check_range(n, 2030, 2060);
      kick_once;
      wait_for(1, 1'h0, 6000, n);
      check_range(n, 4080, 4110);
      $display("external timebase test done");
      kick_run <= 1'h1;
      wait_for(0, 1'h1, 3000, n);
      f0 = falls;
      repeat (8000) @(negedge ref_clk_in);
      check_range(falls - f0, 0, 0);
      kick_run <= 1'h0;
      flt <= 1'h1;
      repeat (6000) @(negedge ref_clk_in);
      check_range(falls - f0, 0, 0);
      check_bit(rst_n_o, 1'h1);
      flt <= 1'h0;
      $display("kick and float test done");
      src_sel <= 1'h1;
      ext_run <= 1'h0;
      long_var <= 1'h1;
      kick_once;
      wait_for(1, 1'h0, 5000, n);
      check_range(n, 3060, 3090);
      sb <= 1'h1;
      repeat (5) @(negedge ref_clk_in);
      check_bit(flag_n, 1'h1);
      check_bit(sl_n, 1'h0);
      sb <= 1'h0;
      wait_for(0, 1'h1, 7000, n);
      check_range(n, 6130, 6160);
      $display("internal timebase test done");
      finish_test;
   end
endmodule
